// file: clock_calendar_space_i2c_slave_interface_tb_top.sv
module clock_calendar_space_i2c_slave_interface_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EE_WC = 1000; // shortened programming time
  localparam int LIMIT = 30000; // core cycles before a hang is cut
  // clocks, pins and bookkeeping
  logic               core_clk;
  logic               link_clk;
  logic               rst_n;
  logic               backup_pwr;
  logic               scl;
  logic               sda_m;
  logic               sda_o;
  logic               sda_oe_n;
  logic               sda_line;
  logic               ee_busy;
  rtsi_pkg::rtsi_wr_t cc_wr;
  int                 fail_count = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  int                 busy_cnt = 0;
  logic               drv_seen = 1'b0;
  logic [15:0]        wr_q[$];
  // open drain line with pull-up
  assign sda_line = sda_m & (sda_oe_n | sda_o);
  // core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // link clock, offset in phase
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  rtsi_slave #(.EE_WC_CYCLES(EE_WC)) u_dut (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .link_clk   (link_clk),
    .scl_i      (scl),
    .sda_i      (sda_line),
    .sda_o      (sda_o),
    .sda_oe_n   (sda_oe_n),
    .backup_pwr (backup_pwr),
    .ee_busy    (ee_busy),
    .cc_wr      (cc_wr)
  );
  rtsi_mst_model u_mst (
    .link_clk (link_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_m    (sda_m)
  );
  // collect written bytes, watch for drive on backup supply
  always @(posedge link_clk)
  begin
    if (cc_wr.valid === 1'b1)
      wr_q.push_back({cc_wr.addr, cc_wr.data});
    if (backup_pwr === 1'b1 && sda_oe_n === 1'b0)
      drv_seen <= 1'b1;
  end
  // busy length and hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (ee_busy === 1'b1)
      busy_cnt <= busy_cnt + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_wr(input logic [15:0] e);
    logic [15:0] g;
    g = (wr_q.size() > 0) ? wr_q.pop_front() : 16'hXXXX;
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected cc_wr expected %h seen %h", e, g);
    end
  endtask
  // byte out, acknowledge judged
  task automatic send(input logic [7:0] d, input logic e);
    logic a;
    u_mst.wr_byte(d, a);
    chk_bit("ack", e, a);
  endtask
  // write wrapping from last sram byte to first register
  task automatic t_write();
    u_mst.start();
    send(8'hDE, 1'b1);
    send(8'h5F, 1'b1);
    send(8'hA5, 1'b1);
    send(8'h3C, 1'b1);
    u_mst.stop();
    chk_wr(16'h5FA5);
    chk_wr(16'h003C);
  endtask
  // read back across the wrap, end with no acknowledge
  task automatic t_read();
    logic [7:0] d;
    logic       r;
    u_mst.start();
    send(8'hDE, 1'b1);
    send(8'h5F, 1'b1);
    u_mst.start();
    send(8'hDF, 1'b1);
    u_mst.rd_byte(1'b1, d, r);
    chk_byte("read 5F", 8'hA5, d);
    u_mst.rd_byte(1'b0, d, r);
    chk_byte("read 00", 8'h3C, d);
    chk_bit("released", 1'b1, r);
    u_mst.tick(6);
    chk_bit("sda_oe_n", 1'b1, sda_oe_n);
    u_mst.stop();
  endtask
  // wrong code, wrong selects, addresses out of range
  task automatic t_refuse();
    u_mst.start();
    send(8'h90, 1'b0);
    send(8'hDE, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(8'hDA, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(8'hDE, 1'b1);
    send(8'h60, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(8'hAE, 1'b1);
    send(8'hEF, 1'b0);
    u_mst.stop();
    chk_byte("notices", 8'h00, 8'(wr_q.size()));
  endtask
  // programming refuses eeprom only, then ends in time
  task automatic t_eeprom();
    int         b0;
    logic [7:0] d;
    logic       r;
    b0 = busy_cnt;
    u_mst.start();
    send(8'hAE, 1'b1);
    send(8'hF0, 1'b1);
    send(8'h55, 1'b1);
    u_mst.stop();
    chk_bit("ee_busy", 1'b1, ee_busy);
    u_mst.start();
    send(8'hAE, 1'b0);
    u_mst.stop();
    u_mst.start();
    send(8'hDE, 1'b1);
    u_mst.stop();
    for (int i = 0; i < 2 * EE_WC && ee_busy !== 1'b0; i++)
      @(posedge core_clk);
    chk_bit("busy length", 1'b1, (busy_cnt - b0 >= EE_WC - 1) && (busy_cnt - b0 <= EE_WC + 1));
    u_mst.start();
    send(8'hAE, 1'b1);
    send(8'hF0, 1'b1);
    u_mst.start();
    send(8'hAF, 1'b1);
    u_mst.rd_byte(1'b0, d, r);
    chk_byte("eeprom F0", 8'h55, d);
    u_mst.stop();
    chk_byte("notices", 8'h00, 8'(wr_q.size()));
  endtask
  // silent on backup supply, back on primary
  task automatic t_backup();
    @(posedge core_clk);
    backup_pwr <= 1'b1;
    repeat (10) @(posedge core_clk);
    u_mst.start();
    send(8'hDE, 1'b0);
    u_mst.stop();
    chk_bit("drive on backup", 1'b0, drv_seen);
    @(posedge core_clk);
    backup_pwr <= 1'b0;
    repeat (10) @(posedge core_clk);
    u_mst.start();
    send(8'hDE, 1'b1);
    u_mst.stop();
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset, then scenarios
  initial
  begin
    rst_n = 1'b0;
    backup_pwr = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge link_clk);
    t_write();
    t_read();
    t_refuse();
    t_eeprom();
    t_backup();
    stop_test();
  end
endmodule

// file: rtsi_evt_xing.sv
module rtsi_evt_xing (
  // source domain
  input  wire logic src_clk,
  input  wire logic src_pulse,
  // destination domain
  input  wire logic dst_clk,
  output logic      dst_pulse,
  // shared asynchronous reset
  input  wire logic rst_n
);

  logic tgl_ff;
  logic tgl_s;
  logic seen_ff;

  // event turns into a toggle so no pulse is lost to the slower side
  always_ff @(posedge src_clk or negedge rst_n)
  begin
    if (!rst_n)
      tgl_ff <= 1'b0;
    else
      tgl_ff <= tgl_ff ^ src_pulse;
  end

  rtsi_sync #(.W(1)) u_sync (
    .clk   (dst_clk),
    .rst_n (rst_n),
    .d     (tgl_ff),
    .q     (tgl_s)
  );

  // edge of the synchronised toggle marks one event
  always_ff @(posedge dst_clk or negedge rst_n)
  begin
    if (!rst_n)
      seen_ff <= 1'b0;
    else
      seen_ff <= tgl_s;
  end

  assign dst_pulse = tgl_s ^ seen_ff;

endmodule

// file: rtsi_mst_model.sv
module rtsi_mst_model (
  // link clock the master steps on
  input  wire logic link_clk,
  // wired-and level of the data line
  input  wire logic sda_line,
  // lines driven by the master
  output logic      scl,
  output logic      sda_m
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 6; // link clocks per scl phase
  // both lines released: bus idle
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // wait n link clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // start, or repeated start from scl low
  task automatic start();
    tick(1);
    if (scl === 1'b0)
    begin
      sda_m <= 1'b1;
      tick(HALF);
      scl <= 1'b1;
      tick(HALF);
    end
    sda_m <= 1'b0;
    tick(HALF);
    scl <= 1'b0;
  endtask
  // stop from scl low, then bus free time
  task automatic stop();
    tick(1);
    sda_m <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_m <= 1'b1;
    tick(2 * HALF);
  endtask
  // one bit per pulse, set in low phase, line sampled mid high
  task automatic bit_xfer(input logic b, output logic s);
    tick(1);
    sda_m <= b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF / 2);
    #1 s = sda_line;
    tick(HALF - HALF / 2);
    scl <= 1'b0;
  endtask
  // byte out msb first, extra pulse for the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // byte in msb first; no acknowledge ends the read
  task automatic rd_byte(input logic ack, output logic [7:0] d, output logic rel);
    for (int i = 7; i >= 0; i--)
      bit_xfer(1'b1, d[i]);
    bit_xfer(~ack, rel);
  endtask
endmodule

// file: rtsi_pkg.sv
package rtsi_pkg;

  // control byte codes and chip-select pattern
  localparam logic [3:0] CODE_EE = 4'hA;
  localparam logic [3:0] CODE_CC = 4'hD;
  localparam logic [2:0] CS_ALL  = 3'h7;

  // implemented locations of each space
  localparam logic [7:0] CC_LO   = 8'h00;
  localparam logic [7:0] CC_HI   = 8'h5F;
  localparam logic [7:0] SRAM_LO = 8'h20;
  localparam logic [7:0] EE_LO   = 8'hF0;
  localparam logic [7:0] EE_HI   = 8'hF7;
  localparam int         CC_DEPTH = 96;
  localparam int         EE_DEPTH = 8;

  // eeprom programming time, longest figure, rounded down to cycles
  localparam int         CORE_CLK_MHZ   = 100;
  localparam int         EE_WC_TIME_MS  = 5;
  localparam int         EE_WC_CYCLES   = EE_WC_TIME_MS * 1000 * CORE_CLK_MHZ;

  // values after reset
  localparam logic [2:0] BIT_RST = 3'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } rtsi_state_t;

  // control byte layout, msb first on the wire
  typedef struct packed {
    logic [3:0] code;
    logic [2:0] cs;
    logic       rd;
  } rtsi_ctl_t;

  // notice of a byte written into the clock/calendar space
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } rtsi_wr_t;

endpackage

// file: rtsi_slave.sv
// How it works
// - sda changing while scl is high is read as start or stop
// - start is sda falling while scl is high
// - stop is sda rising while scl is high
// - both lines high means the bus is idle
// - device is slave only; master makes clock, start, stop, direction
// - one bit per scl pulse, valid while stable over the high phase
// - receiver acknowledges each byte once addressed
// - acknowledger holds sda low over the whole acknowledge high phase
// - on a read not acknowledged the device releases sda
// - eeprom control byte refused while programming; other space still served
// - interface silent and sda released while on backup supply
// - control byte upper four bits pick eeprom 1010 or clock space 1101
// - next three bits are chip selects, always ones
// - last control bit: one reads, zero writes
// - valid slave address is acknowledged, then read or write follows
// - clock space holds registers 00-1F and sram 20-5F
// - eeprom space is locations F0-F7 only
// - address byte outside the selected space is not acknowledged
// - eeprom programming lasts at most 5 ms; access refused meanwhile
module rtsi_slave #(
  parameter int EE_WC_CYCLES = rtsi_pkg::EE_WC_CYCLES
) (
  // core clock domain
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  // link clock, samples the serial pins
  input  wire logic               link_clk,
  // serial pins, sda is open drain
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_n,
  // supply state pin
  input  wire logic               backup_pwr,
  // status and write notice
  output logic                    ee_busy,
  output rtsi_pkg::rtsi_wr_t      cc_wr
);

  localparam int CW = $clog2(EE_WC_CYCLES + 1);

  rtsi_pkg::rtsi_state_t state_ff;
  rtsi_pkg::rtsi_state_t nxt_state;
  rtsi_pkg::rtsi_state_t ack_to_ff;
  rtsi_pkg::rtsi_state_t nxt_ack_to;
  rtsi_pkg::rtsi_ctl_t   ctl;
  rtsi_pkg::rtsi_wr_t    cc_wr_ff;

  logic [7:0]    cc_mem [rtsi_pkg::CC_DEPTH];
  logic [7:0]    ee_mem [rtsi_pkg::EE_DEPTH];
  logic [1:0]    pin_s;
  logic          scl_s;
  logic          sda_s;
  logic          scl_q_ff;
  logic          sda_q_ff;
  logic          bkp_s;
  logic          busy_s;
  logic [2:0]    bit_ff;
  logic [2:0]    nxt_bit;
  logic [7:0]    sh_ff;
  logic [7:0]    nxt_sh;
  logic [7:0]    ptr_ff;
  logic [7:0]    nxt_ptr;
  logic          oe_n_ff;
  logic          nxt_oe_n;
  logic          drv_ff;
  logic          nxt_drv;
  logic          ee_ff;
  logic          nxt_ee;
  logic          mack_ff;
  logic          nxt_mack;
  logic          dirty_ff;
  logic          nxt_dirty;
  logic          pend_ff;
  logic          mem_we;
  logic          ee_fire;
  logic          prog_evt;
  logic [CW-1:0] wc_cnt_ff;
  logic          busy_ff;

  // pins and slow levels enter the link domain through two flip-flops;
  // pin stages reset to the idle-high level so no false edge follows reset
  rtsi_sync #(.W(2), .RST(2'h3)) u_pin_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     ({scl_i, sda_i}),
    .q     (pin_s)
  );

  rtsi_sync #(.W(2)) u_lvl_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     ({backup_pwr, busy_ff}),
    .q     ({bkp_s, busy_s})
  );

  // programming request crosses to the core timer as an event
  rtsi_evt_xing u_prog_xing (
    .src_clk   (link_clk),
    .src_pulse (ee_fire),
    .dst_clk   (core_clk),
    .dst_pulse (prog_evt),
    .rst_n     (rst_n)
  );

  // line decode
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  wire scl_rise  = scl_s & ~scl_q_ff;
  wire scl_fall  = ~scl_s & scl_q_ff;
  wire start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  wire stop_det  = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
  wire bus_idle  = scl_s & sda_s;

  // byte assembly and control byte decode
  wire [7:0] sh_in    = {sh_ff[6:0], sda_s};
  wire       byte_done = scl_rise & (bit_ff == 3'h7);
  assign ctl = rtsi_pkg::rtsi_ctl_t'(sh_in);
  wire       ee_busy_l = busy_s | pend_ff;
  wire       ctl_ee   = ctl.code == rtsi_pkg::CODE_EE;
  wire       ctl_cc   = ctl.code == rtsi_pkg::CODE_CC;
  wire       ctl_ok   = ((ctl_ee & ~ee_busy_l) | ctl_cc) & (ctl.cs == rtsi_pkg::CS_ALL);

  // address range checks and pointer wrap inside each space
  wire addr_ok = ee_ff ? (sh_in >= rtsi_pkg::EE_LO && sh_in <= rtsi_pkg::EE_HI)
                       : (sh_in <= rtsi_pkg::CC_HI);
  wire [7:0] ptr_inc = ee_ff ? ((ptr_ff == rtsi_pkg::EE_HI) ? rtsi_pkg::EE_LO : ptr_ff + 8'h01)
                             : ((ptr_ff == rtsi_pkg::CC_HI) ? rtsi_pkg::CC_LO : ptr_ff + 8'h01);
  wire [7:0] rd_byte = ee_ff ? ee_mem[ptr_ff[2:0]] : cc_mem[ptr_ff[6:0]];
  wire [7:0] rd_next = ee_ff ? ee_mem[ptr_inc[2:0]] : cc_mem[ptr_inc[6:0]];

  // serial engine next state
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_ack_to = ack_to_ff;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_ptr    = ptr_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_drv    = drv_ff;
    nxt_ee     = ee_ff;
    nxt_mack   = mack_ff;
    nxt_dirty  = dirty_ff;
    mem_we     = 1'b0;
    ee_fire    = 1'b0;
    if (bkp_s)
    begin
      nxt_state = rtsi_pkg::ST_IDLE;
      nxt_oe_n  = 1'b1;
      nxt_drv   = 1'b0;
    end
    else if (start_det)
    begin
      nxt_state = rtsi_pkg::ST_CTRL;
      nxt_bit   = rtsi_pkg::BIT_RST;
      nxt_oe_n  = 1'b1;
      nxt_drv   = 1'b0;
      nxt_mack  = 1'b0;
    end
    else if (stop_det)
    begin
      nxt_state = rtsi_pkg::ST_IDLE;
      nxt_oe_n  = 1'b1;
      nxt_drv   = 1'b0;
      ee_fire   = dirty_ff;
      nxt_dirty = 1'b0;
    end
    else
    begin
      unique case (state_ff)
        rtsi_pkg::ST_IDLE,
        rtsi_pkg::ST_IGNORE:
          nxt_oe_n = 1'b1;
        rtsi_pkg::ST_CTRL:
          if (scl_rise)
          begin
            nxt_sh  = sh_in;
            nxt_bit = bit_ff + 3'h1;
            if (byte_done)
            begin
              nxt_state  = ctl_ok ? rtsi_pkg::ST_ACK : rtsi_pkg::ST_IGNORE;
              nxt_ee     = ctl_ee;
              nxt_ack_to = ctl.rd ? rtsi_pkg::ST_RDATA : rtsi_pkg::ST_ADDR;
            end
          end
        rtsi_pkg::ST_ADDR:
          if (scl_rise)
          begin
            nxt_sh  = sh_in;
            nxt_bit = bit_ff + 3'h1;
            if (byte_done)
            begin
              nxt_state  = addr_ok ? rtsi_pkg::ST_ACK : rtsi_pkg::ST_IGNORE;
              nxt_ptr    = addr_ok ? sh_in : ptr_ff;
              nxt_ack_to = rtsi_pkg::ST_WDATA;
            end
          end
        rtsi_pkg::ST_WDATA:
          if (scl_rise)
          begin
            nxt_sh  = sh_in;
            nxt_bit = bit_ff + 3'h1;
            if (byte_done)
            begin
              mem_we     = 1'b1;
              nxt_ptr    = ptr_inc;
              nxt_dirty  = dirty_ff | ee_ff;
              nxt_state  = rtsi_pkg::ST_ACK;
              nxt_ack_to = rtsi_pkg::ST_WDATA;
            end
          end
        rtsi_pkg::ST_ACK:
          if (scl_fall && !drv_ff)
          begin
            nxt_oe_n = 1'b0;
            nxt_drv  = 1'b1;
          end
          else if (scl_fall)
          begin
            nxt_drv   = 1'b0;
            nxt_state = ack_to_ff;
            nxt_bit   = rtsi_pkg::BIT_RST;
            nxt_oe_n  = (ack_to_ff == rtsi_pkg::ST_RDATA) ? rd_byte[7] : 1'b1;
            nxt_sh    = rd_byte;
          end
        rtsi_pkg::ST_RDATA:
          if (scl_fall && bit_ff == 3'h7)
          begin
            nxt_oe_n  = 1'b1;
            nxt_state = rtsi_pkg::ST_RACK;
            nxt_ptr   = ptr_inc;
            nxt_mack  = 1'b0;
          end
          else if (scl_fall)
          begin
            nxt_oe_n = sh_ff[6];
            nxt_sh   = {sh_ff[6:0], 1'b0};
            nxt_bit  = bit_ff + 3'h1;
          end
        rtsi_pkg::ST_RACK:
          if (scl_rise && sda_s)
          begin
            nxt_state = rtsi_pkg::ST_IDLE;
            nxt_oe_n  = 1'b1;
          end
          else if (scl_rise)
            nxt_mack = 1'b1;
          else if (scl_fall && mack_ff)
          begin
            nxt_mack  = 1'b0;
            nxt_state = rtsi_pkg::ST_RDATA;
            nxt_bit   = rtsi_pkg::BIT_RST;
            nxt_sh    = rd_byte;
            nxt_oe_n  = rd_byte[7];
          end
      endcase
    end
  end

  // link domain state
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff  <= rtsi_pkg::ST_IDLE;
      ack_to_ff <= rtsi_pkg::ST_IDLE;
      scl_q_ff  <= 1'b1;
      sda_q_ff  <= 1'b1;
      bit_ff    <= rtsi_pkg::BIT_RST;
      sh_ff     <= rtsi_pkg::BYTE_RST;
      ptr_ff    <= rtsi_pkg::BYTE_RST;
      oe_n_ff   <= 1'b1;
      drv_ff    <= 1'b0;
      ee_ff     <= 1'b0;
      mack_ff   <= 1'b0;
      dirty_ff  <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      ack_to_ff <= nxt_ack_to;
      scl_q_ff  <= scl_s;
      sda_q_ff  <= sda_s;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      ptr_ff    <= nxt_ptr;
      oe_n_ff   <= nxt_oe_n;
      drv_ff    <= nxt_drv;
      ee_ff     <= nxt_ee;
      mack_ff   <= nxt_mack;
      dirty_ff  <= nxt_dirty;
    end
  end

  // local busy covers the gap until the core timer's busy comes back
  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_ff <= 1'b0;
    else if (ee_fire)
      pend_ff <= 1'b1;
    else if (busy_s)
      pend_ff <= 1'b0;
  end

  // storage and write notice
  always_ff @(posedge link_clk)
  begin
    if (mem_we && ee_ff)
      ee_mem[ptr_ff[2:0]] <= sh_in;
    else if (mem_we)
      cc_mem[ptr_ff[6:0]] <= sh_in;
  end

  always_ff @(posedge link_clk or negedge rst_n)
  begin
    if (!rst_n)
      cc_wr_ff <= '0;
    else
      cc_wr_ff <= '{valid: mem_we & ~ee_ff, addr: ptr_ff, data: sh_in};
  end

  // programming timer in the core domain
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wc_cnt_ff <= '0;
      busy_ff   <= 1'b0;
    end
    else if (prog_evt)
    begin
      wc_cnt_ff <= CW'(EE_WC_CYCLES - 1);
      busy_ff   <= 1'b1;
    end
    else if (wc_cnt_ff != '0)
      wc_cnt_ff <= wc_cnt_ff - CW'(1);
    else
      busy_ff   <= 1'b0;
  end

  // outputs
  assign sda_o    = 1'b0;
  assign sda_oe_n = oe_n_ff;
  assign ee_busy  = busy_ff;
  assign cc_wr    = cc_wr_ff;

  // checks of the serial engine and the programming timer
  AST_START_CTRL: assert property (@(posedge link_clk) disable iff (!rst_n)
    start_det && !bkp_s |=> state_ff == rtsi_pkg::ST_CTRL && oe_n_ff)
    else $error("start did not open a control byte");
  AST_STOP_IDLE: assert property (@(posedge link_clk) disable iff (!rst_n)
    stop_det && !bkp_s |=> state_ff == rtsi_pkg::ST_IDLE ##1 state_ff == rtsi_pkg::ST_IDLE || start_det)
    else $error("stop did not return the engine to idle");
  AST_BACKUP_QUIET: assert property (@(posedge link_clk) disable iff (!rst_n)
    bkp_s |=> oe_n_ff && state_ff == rtsi_pkg::ST_IDLE)
    else $error("engine active on backup supply");
  AST_EE_BUSY_NACK: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_CTRL && byte_done && ctl_ee && ee_busy_l && !start_det && !stop_det && !bkp_s
    |=> state_ff == rtsi_pkg::ST_IGNORE)
    else $error("eeprom control byte taken while programming");
  AST_BAD_CTL_NACK: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_IGNORE |-> oe_n_ff)
    else $error("sda driven while ignoring the bus");
  AST_ACK_HELD: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_ACK && drv_ff && scl_s |-> !oe_n_ff)
    else $error("acknowledge not held low over scl high");
  AST_NACK_RELEASE: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_RACK && scl_rise && sda_s && !stop_det && !bkp_s
    |=> state_ff == rtsi_pkg::ST_IDLE && oe_n_ff)
    else $error("sda not released after read not acknowledged");
  AST_DATA_STABLE: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_RDATA && scl_s && scl_q_ff |=> $stable(oe_n_ff) || !scl_q_ff)
    else $error("read data changed while scl high");
  AST_IDLE_RELEASE: assert property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_IDLE |-> oe_n_ff)
    else $error("sda driven on an idle bus");
  AST_WC_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    prog_evt |=> busy_ff && wc_cnt_ff == CW'(EE_WC_CYCLES - 1))
    else $error("programming timer not loaded");
  COV_READ_ACK: cover property (@(posedge link_clk) disable iff (!rst_n)
    state_ff == rtsi_pkg::ST_RACK && scl_rise && !sda_s);
  COV_WRITE_BYTE: cover property (@(posedge link_clk) disable iff (!rst_n) mem_we);
  COV_EE_FIRE: cover property (@(posedge link_clk) disable iff (!rst_n) ee_fire);
  COV_IDLE_BUS: cover property (@(posedge link_clk) disable iff (!rst_n) bus_idle && state_ff == rtsi_pkg::ST_IDLE);

endmodule

// file: rtsi_sync.sv
module rtsi_sync #(
  parameter int         W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in from another domain, level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // two flip-flops; the first is read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= RST;
      q_ff    <= RST;
    end
    else
    begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule
